// ===== hw/ckpre_counter.sv
// Clearable up-counter used for both prescalers.
// Assumes clear and advance are synchronous to clk; clear beats advance.
`timescale 1ns/10ps

module ckpre_counter #(
  parameter int W = 13
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         clear,
  input  wire logic         advance,
  output logic [W-1:0]      count
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (clear) begin
      count_next = '0;
    end else if (advance) begin
      count_next = count_reg + W'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule

// ===== hw/ckpre_defines.svh
// Offsets, field positions, reset values and counts for the clock prescaler block.
// Assumes byte-wide registers reached over a plain strobe port.
`ifndef CKPRE_DEFINES_SVH
`define CKPRE_DEFINES_SVH

`define CKPRE_ADDR_W            4
`define CKPRE_DATA_W            8
`define CKPRE_OFS_PORT_MODE_2     4'h0
`define CKPRE_OFS_SYS_CTRL_1      4'h1
`define CKPRE_OFS_TIMER_A_MODE    4'h2
`define CKPRE_SRC_SEL_BIT         7
`define CKPRE_WAIT_SEL_LSB        4
`define CKPRE_WAIT_SEL_MSB        6
`define CKPRE_TA_CLR_HI_BIT       3
`define CKPRE_TA_CLR_LO_BIT       2
`define CKPRE_PORT_MODE_2_RESET   8'h00
`define CKPRE_SYS_CTRL_1_RESET    8'h00
`define CKPRE_TIMER_A_MODE_RESET  8'h00
`define CKPRE_SYS_W             13
`define CKPRE_SUB_W             5
`define CKPRE_WATCH_DIV_W       2
`define CKPRE_MED_DIV_W         7
`define CKPRE_WAIT_W            18
`define CKPRE_WAIT_MIN          8
`define CKPRE_WAIT_SHORT        16
`define CKPRE_WAIT_LONGEST      131072

`endif

// ===== hw/ckpre_pkg.sv
// Types shared by the clock prescaler block.
// Assumes ckpre_defines.svh supplies the widths.
`include "ckpre_defines.svh"

package ckpre_pkg;

  typedef enum logic [2:0] {
    CKPRE_ACTIVE_HIGH = 3'b000,
    CKPRE_ACTIVE_MED  = 3'b001,
    CKPRE_SLEEP_HIGH  = 3'b010,
    CKPRE_SLEEP_MED   = 3'b011,
    CKPRE_SUBACTIVE   = 3'b100,
    CKPRE_SUBSLEEP    = 3'b101,
    CKPRE_WATCH       = 3'b110,
    CKPRE_STANDBY     = 3'b111
  } ckpre_mode_t;

  typedef struct packed {
    logic [`CKPRE_ADDR_W-1:0] addr;
    logic [`CKPRE_DATA_W-1:0] wdata;
    logic                     wr;
    logic                     rd;
  } ckpre_bus_req_t;

endpackage

// ===== hw/ckpre_top.sv
// System and subclock prescalers, subclock source select and wake wait counter.
// Assumes clk is the oscillator clock, mode comes from the power-mode controller,
// and the subclock pins are already synchronous to clk.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "ckpre_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// - System prescaler is a 13-bit counter, one step per system clock period.
// - Reset clears the system prescaler; counting starts at reset release.
// - Standby, watch, subactive, subsleep stop the system prescaler and zero it.
// - Software can neither read nor write the system prescaler.
// - All peripherals share the system prescaler taps, each choosing its own.
// - Medium-speed mode feeds the prescaler oscillator clock over 16, 32, 64 or 128.
// - Subclock prescaler is 5 bits, fed by the watch clock divided by four.
// - Reset clears the subclock prescaler; counting starts at reset release.
// - Subclock prescaler keeps counting in low-power modes while subclock runs.
// - Writing ones to both timer A clear bits zeroes the subclock prescaler.
// - Subclock prescaler taps go to timer A as its timekeeping base.
// - Port mode register 2 bit 7 picks resonator (0) or external clock (1).
// - External source ignores the resonator and takes the shared port pin.
// - Standby wait select sits in bits 6 to 4 of system control register 1.
// - Wake wait spans at least 8 and at most 131,072 states.
// - Leaving halt restarts the oscillator; CPU resumes after the wait.
module ckpre_top #(
  parameter int WAIT_LONGEST = `CKPRE_WAIT_LONGEST
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire ckpre_pkg::ckpre_bus_req_t   bus_req,
  output logic [`CKPRE_DATA_W-1:0]         bus_rdata,
  input  wire ckpre_pkg::ckpre_mode_t      power_mode,
  input  wire logic [1:0]                  med_div_sel,
  input  wire logic                        subclock_resonator_input,
  input  wire logic                        subclock_external_input,
  output logic [`CKPRE_SYS_W-1:0]          system_prescaler_taps,
  output logic [`CKPRE_SUB_W-1:0]          subclock_prescaler_taps,
  output logic                             shared_port_pin_usable,
  output logic                             cpu_clock_run,
  output logic                             wake_wait_busy
);

  //////////////////////////////////////////////////////////////////////////////
  // Power-mode decoding and the wake wait length table

  function automatic logic mode_halted(input ckpre_pkg::ckpre_mode_t m);
    mode_halted = (m == ckpre_pkg::CKPRE_STANDBY) || (m == ckpre_pkg::CKPRE_WATCH) ||
                  (m == ckpre_pkg::CKPRE_SUBACTIVE) || (m == ckpre_pkg::CKPRE_SUBSLEEP);
  endfunction

  function automatic logic mode_medium(input ckpre_pkg::ckpre_mode_t m);
    mode_medium = (m == ckpre_pkg::CKPRE_ACTIVE_MED) || (m == ckpre_pkg::CKPRE_SLEEP_MED);
  endfunction

  // Longer settings derive from the longest so a simulation can shrink them all.
  function automatic logic [`CKPRE_WAIT_W-1:0] wait_len(input logic [2:0] sel);
    unique case (sel)
      3'h0: wait_len = `CKPRE_WAIT_W'(WAIT_LONGEST >> 4);
      3'h1: wait_len = `CKPRE_WAIT_W'(WAIT_LONGEST >> 3);
      3'h2: wait_len = `CKPRE_WAIT_W'(WAIT_LONGEST >> 2);
      3'h3: wait_len = `CKPRE_WAIT_W'(WAIT_LONGEST >> 1);
      3'h4: wait_len = `CKPRE_WAIT_W'(WAIT_LONGEST);
      3'h5: wait_len = `CKPRE_WAIT_W'(`CKPRE_WAIT_SHORT);
      3'h6: wait_len = `CKPRE_WAIT_W'(`CKPRE_WAIT_MIN);
      3'h7: wait_len = `CKPRE_WAIT_W'(`CKPRE_WAIT_MIN);
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [`CKPRE_DATA_W-1:0] port_mode_2_reg,  port_mode_2_next;
  logic [`CKPRE_DATA_W-1:0] sys_ctrl_1_reg,   sys_ctrl_1_next;
  logic [`CKPRE_DATA_W-1:0] timer_a_mode_reg, timer_a_mode_next;
  logic [`CKPRE_DATA_W-1:0] rdata_reg,        rdata_next;
  logic                     sub_clear;
  logic                     subclock_source_select;
  logic [2:0]               standby_wait_select;

  always_comb begin
    port_mode_2_next  = port_mode_2_reg;
    sys_ctrl_1_next   = sys_ctrl_1_reg;
    timer_a_mode_next = timer_a_mode_reg;
    rdata_next        = '0;
    sub_clear         = 1'b0;
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        `CKPRE_OFS_PORT_MODE_2: port_mode_2_next = bus_req.wdata & 8'h80;
        `CKPRE_OFS_SYS_CTRL_1:  sys_ctrl_1_next  = bus_req.wdata & 8'h70;
        `CKPRE_OFS_TIMER_A_MODE: begin
          timer_a_mode_next = bus_req.wdata & 8'h0f;
          sub_clear = bus_req.wdata[`CKPRE_TA_CLR_HI_BIT] & bus_req.wdata[`CKPRE_TA_CLR_LO_BIT];
        end
        default: ;
      endcase
    end
    // No address reaches the system prescaler count
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `CKPRE_OFS_PORT_MODE_2:  rdata_next = port_mode_2_reg;
        `CKPRE_OFS_SYS_CTRL_1:   rdata_next = sys_ctrl_1_reg;
        `CKPRE_OFS_TIMER_A_MODE: rdata_next = timer_a_mode_reg;
        default:                 rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_mode_2_reg  <= `CKPRE_PORT_MODE_2_RESET;
      sys_ctrl_1_reg   <= `CKPRE_SYS_CTRL_1_RESET;
      timer_a_mode_reg <= `CKPRE_TIMER_A_MODE_RESET;
      rdata_reg        <= 8'h00;
    end else begin
      port_mode_2_reg  <= port_mode_2_next;
      sys_ctrl_1_reg   <= sys_ctrl_1_next;
      timer_a_mode_reg <= timer_a_mode_next;
      rdata_reg        <= rdata_next;
    end
  end

  assign bus_rdata              = rdata_reg;
  assign subclock_source_select = port_mode_2_reg[`CKPRE_SRC_SEL_BIT];
  assign standby_wait_select    = sys_ctrl_1_reg[`CKPRE_WAIT_SEL_MSB:`CKPRE_WAIT_SEL_LSB];

  //////////////////////////////////////////////////////////////////////////////
  // Wake wait

  logic                     halted;
  logic                     halted_reg,    halted_next;
  logic                     wait_busy_reg, wait_busy_next;
  logic [`CKPRE_WAIT_W-1:0] wait_cnt_reg,  wait_cnt_next;

  assign halted = mode_halted(power_mode);

  always_comb begin
    halted_next    = halted;
    wait_busy_next = wait_busy_reg;
    wait_cnt_next  = wait_cnt_reg;
    if (halted) begin
      wait_busy_next = 1'b0;
      wait_cnt_next  = '0;
    end else if (halted_reg) begin
      wait_busy_next = 1'b1;
      wait_cnt_next  = wait_len(standby_wait_select) - `CKPRE_WAIT_W'(1);
    end else if (wait_busy_reg) begin
      if (wait_cnt_reg == '0) begin
        wait_busy_next = 1'b0;
      end else begin
        wait_cnt_next = wait_cnt_reg - `CKPRE_WAIT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      halted_reg    <= 1'b0;
      wait_busy_reg <= 1'b0;
      wait_cnt_reg  <= '0;
    end else begin
      halted_reg    <= halted_next;
      wait_busy_reg <= wait_busy_next;
      wait_cnt_reg  <= wait_cnt_next;
    end
  end

  // Clocks stay gated from the halt until the wait has fully run out
  assign cpu_clock_run  = !halted && !halted_reg && !wait_busy_reg;
  assign wake_wait_busy = wait_busy_reg;

  //////////////////////////////////////////////////////////////////////////////
  // System prescaler

  logic [`CKPRE_MED_DIV_W-1:0] med_cnt_reg, med_cnt_next;
  logic                        sys_tick;
  logic                        sys_clear;
  logic [`CKPRE_MED_DIV_W-1:0] med_mask;

  always_comb begin
    unique case (med_div_sel)
      2'h0: med_mask = 7'h0f;
      2'h1: med_mask = 7'h1f;
      2'h2: med_mask = 7'h3f;
      2'h3: med_mask = 7'h7f;
    endcase
    med_cnt_next = halted ? '0 : med_cnt_reg + 7'h01;
    sys_tick     = 1'b1;
    if (mode_medium(power_mode)) begin
      sys_tick = ((med_cnt_reg & med_mask) == med_mask);
    end
    sys_clear = halted || halted_reg || wait_busy_reg;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      med_cnt_reg <= '0;
    end else begin
      med_cnt_reg <= med_cnt_next;
    end
  end

  // Reset and halt both zero it; one tap bus serves every peripheral
  ckpre_counter #(.W(`CKPRE_SYS_W)) u_system_prescaler (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clear   (sys_clear),
    .advance (sys_tick),
    .count   (system_prescaler_taps)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Subclock source and prescaler

  logic                          sub_level;
  logic                          sub_level_reg, sub_level_next;
  logic [`CKPRE_WATCH_DIV_W-1:0] wdiv_reg,      wdiv_next;
  logic                          sub_tick;

  // Resonator input is ignored entirely once external source is picked
  assign sub_level              = subclock_source_select ? subclock_external_input
                                                         : subclock_resonator_input;
  assign shared_port_pin_usable = !subclock_source_select;

  always_comb begin
    sub_level_next = sub_level;
    wdiv_next      = wdiv_reg;
    sub_tick       = 1'b0;
    if (sub_clear) begin
      wdiv_next = '0;
    end else if (sub_level && !sub_level_reg) begin
      wdiv_next = wdiv_reg + 2'h1;
      sub_tick  = (wdiv_reg == 2'h3);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sub_level_reg <= 1'b0;
      wdiv_reg      <= '0;
    end else begin
      sub_level_reg <= sub_level_next;
      wdiv_reg      <= wdiv_next;
    end
  end

  // Power mode plays no part here, so it runs on through every low-power mode
  ckpre_counter #(.W(`CKPRE_SUB_W)) u_subclock_prescaler (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clear   (sub_clear),
    .advance (sub_tick),
    .count   (subclock_prescaler_taps)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_wake;
    halted_reg && !halted;
  endsequence

  sequence s_wait_hold;
    wait_busy_reg && !cpu_clock_run;
  endsequence

  a_sys_step_fast: assert property (
    (power_mode == ckpre_pkg::CKPRE_ACTIVE_HIGH) && !sys_clear
    |=> system_prescaler_taps == $past(system_prescaler_taps) + 13'h0001)
    else $error("system prescaler missed a step");

  a_sys_zero_halt: assert property (halted |=> system_prescaler_taps == 13'h0000)
    else $error("system prescaler not zero in halt");

  a_sys_med_hold: assert property (
    mode_medium(power_mode) && !sys_tick && !sys_clear |=> $stable(system_prescaler_taps))
    else $error("system prescaler moved between medium ticks");

  a_wake_wait_min: assert property (s_wake ##1 1'b1 |-> s_wait_hold [*8])
    else $error("wake wait shorter than eight states");

  a_wake_wait_len: assert property (
    s_wake ##1 (standby_wait_select == 3'h6) |-> wait_busy_reg [*8] ##1 !wait_busy_reg)
    else $error("wake wait length wrong");

  // Checks the counter output too, so a broken clear path cannot hide behind the gate
  a_wait_blocks_cpu: assert property (wait_busy_reg |-> !cpu_clock_run ##1 system_prescaler_taps == 13'h0000)
    else $error("cpu or prescaler ran during wake wait");

  a_sub_clear_bits: assert property (
    bus_req.wr && bus_req.addr == `CKPRE_OFS_TIMER_A_MODE && bus_req.wdata[3] && bus_req.wdata[2]
    |=> subclock_prescaler_taps == 5'h00)
    else $error("subclock prescaler not cleared");

  a_sub_div_four: assert property (!sub_tick && !sub_clear |=> $stable(subclock_prescaler_taps))
    else $error("subclock prescaler moved without quarter tick");

  a_src_port_pin: assert property (
    bus_req.wr && bus_req.addr == `CKPRE_OFS_PORT_MODE_2
    |=> shared_port_pin_usable == !$past(bus_req.wdata[7]))
    else $error("port pin state does not follow source select");

  a_sts_field: assert property (
    bus_req.wr && bus_req.addr == `CKPRE_OFS_SYS_CTRL_1
    |=> standby_wait_select == $past(bus_req.wdata[6:4]))
    else $error("standby wait select not stored");

endmodule

// ===== tb/ckpre_subclk_model.sv
// Partner model: the subclock sources that feed the prescaler block.
// Assumes run and use_ext change by non-blocking assignment at rising clk edges.
`timescale 1ns/10ps

module ckpre_subclk_model (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic use_ext,
  output logic      resonator,
  output logic      external
);
  logic [2:0] phase_reg;
  logic [2:0] phase_next;

  ////////////////////////////////////////////////////////////////////////////////
  // One source rise every 8 clk cycles while run is high
  always_comb begin
    phase_next = run ? phase_reg + 3'h1 : 3'h0;
  end

  always_ff @(posedge clk) begin
    phase_reg <= phase_next;
  end

  // Idle lines sit low, as an unused subclock pin is tied to ground
  assign resonator = run & ~use_ext & phase_reg[2];
  assign external  = run & use_ext & phase_reg[2];
endmodule

// ===== tb/tb_ckpre_top.sv
// Self-checking bench for the clock prescaler block.
// Assumes a wait table scaled by WAIT_LONGEST = 128 and synchronous subclock lines.
`timescale 1ns/10ps
`include "ckpre_defines.svh"

module tb_ckpre_top;
  logic                        clk;
  logic                        sys_rst;
  ckpre_pkg::ckpre_bus_req_t   bus_req;
  logic [7:0]                  bus_rdata;
  ckpre_pkg::ckpre_mode_t      power_mode;
  logic [1:0]                  med_div_sel;
  logic                        sub_run;
  logic                        sub_ext;
  logic                        res_line;
  logic                        ext_line;
  logic [`CKPRE_SYS_W-1:0]     sys_taps;
  logic [`CKPRE_SUB_W-1:0]     sub_taps;
  logic                        pin_usable;
  logic                        cpu_clock_run;
  logic                        wake_wait_busy;
  logic [7:0]                  exp_q[$];
  logic                        rd_seen = 1'b0;
  logic [31:0]                 rng = 32'h40;
  logic [12:0]                 t0;
  logic [7:0]                  v;
  logic                        b;
  logic                        bad;
  int                          n;
  int                          fails = 0;
  int                          comparisons = 0;
  int                          wt[8] = '{8, 16, 32, 64, 128, 16, 8, 8};
  logic [3:0]                  addrs[4] = '{4'h0, 4'h1, 4'h2, 4'hf};
  logic [7:0]                  masks[4] = '{8'h80, 8'h70, 8'h0f, 8'h00};

  ckpre_top #(.WAIT_LONGEST(128)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .power_mode(power_mode), .med_div_sel(med_div_sel),
    .subclock_resonator_input(res_line), .subclock_external_input(ext_line),
    .system_prescaler_taps(sys_taps), .subclock_prescaler_taps(sub_taps),
    .shared_port_pin_usable(pin_usable), .cpu_clock_run(cpu_clock_run),
    .wake_wait_busy(wake_wait_busy)
  );

  ckpre_subclk_model i_src (
    .clk(clk), .run(sub_run), .use_ext(sub_ext), .resonator(res_line), .external(ext_line)
  );

  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function logic [7:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction

  // Called at an edge; the strobe stays up until the next call or bus_end
  task bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
    if (r)
      exp_q.push_back(e);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge clk);
  endtask

  task bus_end();
    bus_req <= '0;
  endtask

  task wr1(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d, 8'h00);
    bus_end();
    @(posedge clk);
  endtask

  // Exactly cnt source rises on the chosen line, then a short settle
  task src(input logic e, input int cnt);
    sub_run <= 1'b1;
    sub_ext <= e;
    repeat (cnt * 8) @(posedge clk);
    sub_run <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen && exp_q.size() > 0)
      check(bus_rdata, exp_q.pop_front());
    rd_seen <= bus_req.rd;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run();
  end

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    bus_req = '0;
    power_mode = ckpre_pkg::CKPRE_ACTIVE_HIGH;
    med_div_sel = 2'h0;
    sub_run = 1'b0;
    sub_ext = 1'b0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    check(sys_taps, 16'h0001);
    check(sub_taps, 16'h0000);
    repeat (19) @(posedge clk);
    check(sys_taps, 16'h0014);
    t0 = sys_taps;
    for (int i = 0; i < 4; i++)
      bus(1'b0, 1'b1, addrs[i], 8'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = xs();
      bus(1'b1, 1'b0, addrs[i], v, 8'h00);
      bus(1'b0, 1'b1, addrs[i], 8'h00, v & masks[i]);
    end
    bus_end();
    @(posedge clk);
    check(13'(sys_taps - t0), 16'd13);
    // Long settle lets the divider realign after each ratio change
    for (int s = 0; s < 4; s++) begin
      power_mode <= (s % 2 == 1) ? ckpre_pkg::CKPRE_SLEEP_MED : ckpre_pkg::CKPRE_ACTIVE_MED;
      med_div_sel <= 2'(s);
      repeat (256) @(posedge clk);
      t0 = sys_taps;
      repeat (128) @(posedge clk);
      check(13'(sys_taps - t0), 16'(128 >> (4 + s)));
    end
    power_mode <= ckpre_pkg::CKPRE_STANDBY;
    wr1(4'h0, 8'h00);
    wr1(4'h2, 8'h0c);
    check(sub_taps, 16'h0000);
    src(1'b0, 32);
    check(sub_taps, 16'h0008);
    check(sys_taps, 16'h0000);
    check(pin_usable, 16'h0001);
    wr1(4'h2, 8'h08);
    check(sub_taps, 16'h0008);
    wr1(4'h2, 8'h0c);
    check(sub_taps, 16'h0000);
    wr1(4'h0, 8'h80);
    check(pin_usable, 16'h0000);
    src(1'b0, 16);
    check(sub_taps, 16'h0000);
    src(1'b1, 16);
    check(sub_taps, 16'h0004);
    wr1(4'h0, 8'h00);
    src(1'b1, 16);
    check(sub_taps, 16'h0004);
    src(1'b0, 128);
    check(sub_taps, 16'h0004);
    for (int s = 0; s < 8; s++) begin
      wr1(4'h1, 8'(s << 4));
      power_mode <= ckpre_pkg::ckpre_mode_t'(3'(4 + s % 4));
      repeat (4) @(posedge clk);
      check(sys_taps, 16'h0000);
      check(cpu_clock_run, 16'h0000);
      power_mode <= ckpre_pkg::CKPRE_ACTIVE_HIGH;
      n = 0;
      bad = 1'b0;
      b = 1'b1;
      for (int i = 0; i < 300 && !(n > 0 && !b); i++) begin
        @(posedge clk);
        b = (wake_wait_busy === 1'b1);
        if (b) begin
          n++;
          if (cpu_clock_run !== 1'b0 || sys_taps !== '0)
            bad = 1'b1;
        end
      end
      check(16'(n), 16'(wt[s]));
      check(bad, 16'h0000);
      check(cpu_clock_run, 16'h0001);
    end
    // Second reset while the subclock prescaler holds a nonzero count and the system prescaler is still zero from the wake wait
    sys_rst <= 1'b1;
    @(posedge clk);
    check(sub_taps, 16'h0000);
    check(sys_taps, 16'h0000);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    check(sys_taps, 16'h0001);
    complete_run();
  end
endmodule
